// >>> core/ppvs_map.svh
// Constants of the panel power and video sequencer
`ifndef PPVS_MAP_SVH
`define PPVS_MAP_SVH
`define PPVS_CLK_HZ 50000000
`define PPVS_MS_CYCLES (`PPVS_CLK_HZ / 1000)
`define PPVS_BLACK_MAX_MS 80
`define PPVS_HPD_MAX_MS 80
`define PPVS_HPD_MS 40
`define PPVS_VIDEO_MAX_MS 50
`define PPVS_VIDEO_MS 20
`define PPVS_LINE_ACTIVE 1920
`define PPVS_LINE_TOTAL_MIN 2060
`define PPVS_LINE_TOTAL_MAX 2100
`define PPVS_FRAME_ACTIVE 1080
`define PPVS_FRAME_TOTAL_MIN 1196
`define PPVS_FRAME_TOTAL_MAX 1204
`define PPVS_NOVIDEO_BIT 3
`endif

// >>> core/ppvs_pkg.sv
// Types of the panel power and video sequencer
package ppvs_pkg;
  typedef enum logic [3:0] {
    PPVS_OFF = 4'h1,
    PPVS_BLACK = 4'h2,
    PPVS_CHECK = 4'h4,
    PPVS_SHOW = 4'h8
  } ppvs_state_t;
endpackage

// >>> core/ppvs_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module ppvs_skid #(
  parameter int WIDTH = 24
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem [2];
  logic wrPtr;
  logic rdPtr;
  logic [1:0] count;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= 1'b0;
      rdPtr <= 1'b0;
      count <= 2'h0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= ~wrPtr;
      end
      if (pop) begin
        rdPtr <= ~rdPtr;
      end
      case ({push, pop})
        2'b10: begin
          count <= count + 2'h1;
          inReady <= (count == 2'h0);
          outValid <= 1'b1;
        end
        2'b01: begin
          count <= count - 2'h1;
          inReady <= 1'b1;
          outValid <= (count == 2'h2);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  assign outData = mem[rdPtr];
endmodule

// >>> core/ppvs_sequencer.sv
// Sink-side power, hot-plug, black video and raster check sequencer
`timescale 1ns/1ps
`include "ppvs_map.svh"

// Overview of operation
// - Each line has 1920 active pixels and 2060 to 2100 total pixels.
// - Each frame has 1080 active lines and 1196 to 1204 total lines.
// - At 165 Hz the pixel clock lies between 406.52 and 417.19 MHz.
// - At 60 Hz the raster is unchanged, pixel clock 147.83 to 151.7 MHz.
// - Black video starts by itself within 80 ms of logic supply up.
// - Hot-plug detect goes high within 80 ms; AUX ready before that.
// - AUX polling tolerated from supply up and answered within the window.
// - Within 50 ms of valid video, show it, end black, set status bit.
// - Backlight off before video ends; sink clears status and goes black.
// - No-video flag in stream ID bit 3 forces black video.
// - Automatic black video may be disabled for debugging.
module ppvs_sequencer #(
  parameter int HPD_MS = `PPVS_HPD_MS,
  parameter int VIDEO_MS = `PPVS_VIDEO_MS,
  parameter int MS_CYCLES = `PPVS_MS_CYCLES,
  parameter int PIX_WIDTH = 24
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic supplyGood,
  input wire logic auxReady,
  input wire logic linkVideoValid,
  input wire logic [7:0] streamId,
  input wire logic blackDisable,
  input wire logic pixValid,
  output logic pixReady,
  input wire logic [PIX_WIDTH-1:0] pixData,
  input wire logic pixLineEnd,
  input wire logic pixFrameEnd,
  input wire logic pixActive,
  output logic hotPlugDetect,
  output logic blackVideo,
  output logic sinkStatusValid,
  output logic rasterError,
  output logic dispValid,
  input wire logic dispReady,
  output logic [PIX_WIDTH-1:0] dispData
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] supplySync;
  logic [1:0] auxSync;
  logic [1:0] videoSync;
  logic [1:0] disableSync;
  logic [1:0] noVideoSync;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      supplySync <= 2'h0;
      auxSync <= 2'h0;
      videoSync <= 2'h0;
      disableSync <= 2'h0;
      noVideoSync <= 2'h0;
    end else begin
      supplySync <= {supplySync[0], supplyGood};
      auxSync <= {auxSync[0], auxReady};
      videoSync <= {videoSync[0], linkVideoValid};
      disableSync <= {disableSync[0], blackDisable};
      noVideoSync <= {noVideoSync[0], streamId[`PPVS_NOVIDEO_BIT]};
    end
  end

  logic supplyUp;
  logic videoGood;
  assign supplyUp = supplySync[1];
  assign videoGood = videoSync[1] && !noVideoSync[1];

  // ----------------------------------------
  // Millisecond timebase
  // ----------------------------------------
  // Restarted on every state change so each wait counts from its own event
  logic [31:0] cycleCount;
  logic [15:0] msCount;
  logic msTick;
  logic stateChange;

  assign msTick = (cycleCount == 32'(MS_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cycleCount <= 32'h0;
      msCount <= 16'h0;
    end else if (stateChange) begin
      cycleCount <= 32'h0;
      msCount <= 16'h0;
    end else if (msTick) begin
      cycleCount <= 32'h0;
      msCount <= msCount + 16'h1;
    end else begin
      cycleCount <= cycleCount + 32'h1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  ppvs_pkg::ppvs_state_t state;
  ppvs_pkg::ppvs_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      ppvs_pkg::PPVS_OFF: begin
        if (supplyUp) begin
          next_state = ppvs_pkg::PPVS_BLACK;
        end
      end
      ppvs_pkg::PPVS_BLACK: begin
        if (!supplyUp) begin
          next_state = ppvs_pkg::PPVS_OFF;
        end else if (videoGood && hotPlugDetect) begin
          next_state = ppvs_pkg::PPVS_CHECK;
        end
      end
      ppvs_pkg::PPVS_CHECK: begin
        if (!supplyUp) begin
          next_state = ppvs_pkg::PPVS_OFF;
        end else if (!videoGood) begin
          next_state = ppvs_pkg::PPVS_BLACK;
        end else if (msCount == 16'(VIDEO_MS)) begin
          next_state = ppvs_pkg::PPVS_SHOW;
        end
      end
      ppvs_pkg::PPVS_SHOW: begin
        if (!supplyUp) begin
          next_state = ppvs_pkg::PPVS_OFF;
        end else if (!videoGood) begin
          next_state = ppvs_pkg::PPVS_BLACK;
        end
      end
      default: begin
        next_state = ppvs_pkg::PPVS_OFF;
      end
    endcase
  end

  assign stateChange = (next_state != state);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ppvs_pkg::PPVS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Hot-plug detect
  // ----------------------------------------
  // Raised only once AUX is ready, well inside the 80 ms window
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hotPlugDetect <= 1'b0;
    end else if (!supplyUp) begin
      hotPlugDetect <= 1'b0;
    end else if (state == ppvs_pkg::PPVS_BLACK && auxSync[1] &&
                 msCount >= 16'(HPD_MS)) begin
      hotPlugDetect <= 1'b1;
    end
  end

  // ----------------------------------------
  // Black video and sink status
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      blackVideo <= 1'b0;
      sinkStatusValid <= 1'b0;
    end else begin
      sinkStatusValid <= (next_state == ppvs_pkg::PPVS_SHOW);
      // Debug override keeps the raw stream visible
      blackVideo <= (next_state == ppvs_pkg::PPVS_BLACK ||
                     next_state == ppvs_pkg::PPVS_CHECK) &&
                    !disableSync[1];
    end
  end

  // ----------------------------------------
  // Raster check
  // ----------------------------------------
  // Same limits hold for both refresh rates; only pixel clock differs
  logic [11:0] pixCount;
  logic [11:0] activeCount;
  logic [11:0] lineCount;
  logic [11:0] activeLines;
  logic lineHadActive;
  logic inTake;
  logic lineBad;
  logic frameBad;

  assign inTake = pixValid && pixReady;
  assign lineBad = (activeCount + 12'(pixActive) != 12'(`PPVS_LINE_ACTIVE)) ||
                   (pixCount + 12'h1 < 12'(`PPVS_LINE_TOTAL_MIN)) ||
                   (pixCount + 12'h1 > 12'(`PPVS_LINE_TOTAL_MAX));
  // Last line counts as active if its closing beat is, same as the line path
  assign frameBad =
    (activeLines + 12'(lineHadActive || pixActive) != 12'(`PPVS_FRAME_ACTIVE)) ||
    (lineCount + 12'h1 < 12'(`PPVS_FRAME_TOTAL_MIN)) ||
    (lineCount + 12'h1 > 12'(`PPVS_FRAME_TOTAL_MAX));

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pixCount <= 12'h0;
      activeCount <= 12'h0;
      lineCount <= 12'h0;
      activeLines <= 12'h0;
      lineHadActive <= 1'b0;
      rasterError <= 1'b0;
    end else if (state != ppvs_pkg::PPVS_SHOW && state != ppvs_pkg::PPVS_CHECK) begin
      pixCount <= 12'h0;
      activeCount <= 12'h0;
      lineCount <= 12'h0;
      activeLines <= 12'h0;
      lineHadActive <= 1'b0;
      rasterError <= 1'b0;
    end else if (inTake) begin
      if (pixLineEnd) begin
        pixCount <= 12'h0;
        activeCount <= 12'h0;
        lineHadActive <= 1'b0;
        if (lineBad) begin
          rasterError <= 1'b1;
        end
        if (pixFrameEnd) begin
          lineCount <= 12'h0;
          activeLines <= 12'h0;
          if (frameBad) begin
            rasterError <= 1'b1;
          end
        end else begin
          lineCount <= lineCount + 12'h1;
          activeLines <= activeLines + 12'(lineHadActive || pixActive);
        end
      end else begin
        pixCount <= pixCount + 12'h1;
        activeCount <= activeCount + 12'(pixActive);
        lineHadActive <= lineHadActive || pixActive;
      end
    end
  end

  // ----------------------------------------
  // Pixel path
  // ----------------------------------------
  // Black replaces data in the buffer path so no noise reaches the panel
  logic [PIX_WIDTH-1:0] bufIn;
  logic [PIX_WIDTH-1:0] bufOut;
  logic bufValid;
  logic bufReady;

  assign bufIn = blackVideo ? '0 : pixData;

  ppvs_skid #(
    .WIDTH(PIX_WIDTH)
  ) i_ppvs_skid (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inValid(pixValid),
    .inReady(bufReady),
    .inData(bufIn),
    .outValid(bufValid),
    .outReady(dispReady || !dispValid),
    .outData(bufOut)
  );

  assign pixReady = bufReady;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dispValid <= 1'b0;
      dispData <= '0;
    end else if (dispReady || !dispValid) begin
      dispValid <= bufValid;
      dispData <= bufOut;
    end
  end
endmodule

// >>> sim/ppvs_sequencer_monitor.sv
// Assertion checker on the sequencer ports
`timescale 1ns/1ps
module ppvs_sequencer_monitor #(
  parameter int HPD_MS = 40,
  parameter int VIDEO_MS = 20,
  parameter int MS_CYCLES = 10
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic supplyGood,
  input wire logic auxReady,
  input wire logic linkVideoValid,
  input wire logic [7:0] streamId,
  input wire logic blackDisable,
  input wire logic hotPlugDetect,
  input wire logic blackVideo,
  input wire logic sinkStatusValid
);
  // ---
  // Checks, bounds sized for a 10-cycle millisecond
  // ---
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  black_start_a: assert property (
    $rose(supplyGood) && !blackDisable |-> ##[1:8] blackVideo) else $error("black late");
  hpd_bound_a: assert property (
    $rose(supplyGood) |-> ##[1:808] (hotPlugDetect || !supplyGood)) else $error("hpd late");
  hpd_cause_a: assert property (
    $rose(hotPlugDetect) |-> supplyGood && auxReady) else $error("hpd before aux");
  hpd_off_a: assert property (
    !supplyGood [*4] |-> !hotPlugDetect) else $error("hpd without supply");
  status_cause_a: assert property (
    $rose(sinkStatusValid) |-> $past(linkVideoValid, 190) && hotPlugDetect)
    else $error("status too early");
  status_clean_a: assert property (
    $rose(sinkStatusValid) |-> !blackVideo) else $error("black with status");
  video_end_a: assert property (
    $fell(linkVideoValid) && supplyGood && !blackDisable
      |-> ##[1:8] (!sinkStatusValid && blackVideo)) else $error("no black at video end");
  novideo_black_a: assert property (
    $rose(streamId[3]) && hotPlugDetect && !blackDisable |-> ##[1:8] blackVideo)
    else $error("flag ignored");
  debug_off_a: assert property (
    blackDisable [*6] |-> !blackVideo) else $error("black while disabled");
endmodule

bind ppvs_sequencer ppvs_sequencer_monitor #(.HPD_MS(HPD_MS), .VIDEO_MS(VIDEO_MS),
  .MS_CYCLES(MS_CYCLES)) i_ppvs_sequencer_monitor (.sys_clk(sys_clk), .resetn(resetn),
  .supplyGood(supplyGood), .auxReady(auxReady), .linkVideoValid(linkVideoValid),
  .streamId(streamId), .blackDisable(blackDisable), .hotPlugDetect(hotPlugDetect),
  .blackVideo(blackVideo), .sinkStatusValid(sinkStatusValid));

// >>> sim/ppvs_source_model.sv
// Graphics source model: supply, AUX, link video, backlight
`timescale 1ns/1ps
module ppvs_source_model (
  input wire logic sys_clk,
  input wire logic wantPower,
  input wire logic wantVideo,
  input wire logic hotPlugDetect,
  output logic supplyGood,
  output logic auxReady,
  output logic linkVideoValid,
  output logic backlightOn
);
  int trainCnt = 0;
  int videoCnt = 0;
  int railCnt = 0;
  int offCnt = 0;
  logic backlightRail = 0;
  initial begin
    supplyGood = 0;
    auxReady = 0;
    linkVideoValid = 0;
    backlightOn = 0;
  end
  // ---
  // Sequencing, 800 cycles is 80 ms here
  // ---
  always @(negedge sys_clk) begin
    supplyGood <= wantPower;
    auxReady <= supplyGood;
    trainCnt <= hotPlugDetect ? trainCnt + 1 : 0;
    linkVideoValid <= wantVideo ? (linkVideoValid || trainCnt > 8)
      : (linkVideoValid && backlightOn);
    videoCnt <= linkVideoValid ? videoCnt + 1 : 0;
    // Rail leads dimming by 1 ms and outlives it by 1 ms
    backlightRail <= wantVideo ? (backlightRail || videoCnt >= 790)
      : (backlightRail && offCnt < 10);
    railCnt <= backlightRail ? railCnt + 1 : 0;
    backlightOn <= wantVideo && videoCnt >= 800 && railCnt >= 10;
    offCnt <= backlightOn ? 0 : offCnt + 1;
  end
endmodule

// >>> sim/ppvs_sequencer_tb_top.sv
// Testbench of the panel power and video sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
  $display("Error %0t: mismatch", $time); end end
`define WAIT(c, lim) begin n = 0; while (!(c) && n < lim) begin @(negedge sys_clk); n++; end end
module ppvs_sequencer_tb_top;
  logic sys_clk = 0, resetn = 0, wantPower = 0, wantVideo = 0, blackDisable = 0;
  logic pixValid = 0, pixLineEnd = 0, dispReady = 1, pixFrameEnd = 0, pixActive = 1;
  logic supplyGood, auxReady, linkVideoValid, backlightOn, pixReady;
  logic hotPlugDetect, blackVideo, sinkStatusValid, rasterError, dispValid;
  logic [7:0] streamId = 8'h00;
  logic [23:0] pixData = 24'h000000;
  logic [23:0] dispData;
  logic [23:0] q[$];
  int fail_count = 0, n_tests = 0, cycles = 0, n, k;
  initial forever #10 sys_clk = ~sys_clk;
  ppvs_source_model i_ppvs_source_model (.sys_clk(sys_clk), .wantPower(wantPower),
    .wantVideo(wantVideo), .hotPlugDetect(hotPlugDetect), .supplyGood(supplyGood),
    .auxReady(auxReady), .linkVideoValid(linkVideoValid), .backlightOn(backlightOn));
  ppvs_sequencer #(.MS_CYCLES(10)) i_ppvs_sequencer (.sys_clk(sys_clk), .resetn(resetn),
    .supplyGood(supplyGood), .auxReady(auxReady), .linkVideoValid(linkVideoValid),
    .streamId(streamId), .blackDisable(blackDisable), .pixValid(pixValid),
    .pixReady(pixReady), .pixData(pixData), .pixLineEnd(pixLineEnd),
    .pixFrameEnd(pixFrameEnd),
    .pixActive(pixActive), .hotPlugDetect(hotPlugDetect), .blackVideo(blackVideo),
    .sinkStatusValid(sinkStatusValid), .rasterError(rasterError), .dispValid(dispValid),
    .dispReady(dispReady), .dispData(dispData));
  // ---
  // Helpers
  // ---
  task automatic test_done;
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Called just after a falling edge; valid drops while refused
  task automatic push(input logic [23:0] d, input logic le);
    int w;
    w = 0;
    while (!pixReady && w < 100) begin
      pixValid = 0;
      @(negedge sys_clk);
      w++;
    end
    pixValid = 1;
    pixData = d;
    pixLineEnd = le;
    q.push_back(d);
    @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (resetn && dispValid === 1'b1 && dispReady === 1'b1) begin
      if (q.size() == 0) begin
        fail_count++;
        $display("Error %0t: unexpected pixel", $time);
      end else
        `CHK(dispData, q.pop_front())
    end
    if (cycles > 20000) begin
      fail_count++;
      test_done();
    end
  end
  // ---
  // Scenarios
  // ---
  initial begin
    k = $urandom(88);
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1;
    wantPower = 1;
    `WAIT(blackVideo === 1'b1, 10)
    `CHK(blackVideo, 1'b1)
    `CHK(hotPlugDetect, 1'b0)
    `WAIT(hotPlugDetect === 1'b1, 820)
    `CHK(n >= 350 && n <= 800, 1'b1)
    $display("Power-up test done");
    wantVideo = 1;
    `WAIT(linkVideoValid === 1'b1, 50)
    `WAIT(sinkStatusValid === 1'b1, 600)
    `CHK(n >= 190 && n <= 500, 1'b1)
    `CHK(blackVideo, 1'b0)
    $display("Video start test done");
    dispReady = 0;
    k = 0;
    while (pixReady && k < 8) begin
      k++;
      push(24'($urandom), 1'b0);
    end
    pixValid = 0;
    `CHK(pixReady, 1'b0)
    `CHK(k >= 2, 1'b1)
    repeat (20) @(negedge sys_clk) dispReady = 1'($urandom);
    @(negedge sys_clk) dispReady = 1;
    for (k = 0; k < 20; k++) push(24'($urandom), k == 19);
    pixValid = 0;
    pixLineEnd = 0;
    `WAIT(q.size() == 0, 50)
    `CHK(q.size() == 0, 1'b1)
    repeat (10) @(negedge sys_clk);
    `CHK(rasterError, 1'b1)
    $display("Buffer and raster test done");
    streamId = {4'($urandom), 1'b1, 3'($urandom)};
    `WAIT(blackVideo === 1'b1, 10)
    `CHK(blackVideo, 1'b1)
    streamId = {4'($urandom), 1'b0, 3'($urandom)};
    repeat (300) @(negedge sys_clk);
    `CHK(rasterError, 1'b0)
    for (k = 0; k < 4160; k++) begin
      pixActive = (k % 2080) < 1920;
      pixFrameEnd = (k == 4159);
      push(24'($urandom), (k % 2080) == 2079);
      if (k == 2079) `CHK(rasterError, 1'b0)
    end
    pixValid = 0;
    pixLineEnd = 0;
    pixFrameEnd = 0;
    `WAIT(q.size() == 0, 50)
    repeat (2) @(negedge sys_clk);
    `CHK(rasterError, 1'b1)
    $display("Full line and short frame test done");
    wantVideo = 0;
    `WAIT(sinkStatusValid === 1'b0, 900)
    repeat (10) @(negedge sys_clk);
    `CHK(sinkStatusValid, 1'b0)
    `CHK(blackVideo, 1'b1)
    $display("Video end test done");
    blackDisable = 1;
    repeat (10) @(negedge sys_clk);
    `CHK(blackVideo, 1'b0)
    blackDisable = 0;
    repeat (10) @(negedge sys_clk);
    `CHK(blackVideo, 1'b1)
    wantPower = 0;
    repeat (10) @(negedge sys_clk);
    `CHK(hotPlugDetect, 1'b0)
    $display("Debug and power-off test done");
    test_done();
  end
endmodule
